// File: pfr_pkg.sv
package pfr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned CLK_PER_MS        = CLK_HZ / 1000;
    localparam int unsigned T_REC_TYP_MS      = 250;
    localparam int unsigned T_REC_MAX_MS      = 300;
    localparam int unsigned T_RST_ACTIVE_MS   = 250;
    localparam int unsigned T_PB_DEBOUNCE_MS  = 250;
    localparam int unsigned T_OSC_STOP_MS     = 100;

    // ------------------------------------------------------------
    // Control settings register
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_SETTINGS_OFFSET = 8'h0e;
    localparam logic [7:0] CONTROL_SETTINGS_RESET  = 8'h1c;
    localparam int unsigned BIT_ALARM1_IRQ_EN      = 0;
    localparam int unsigned BIT_ALARM2_IRQ_EN      = 1;
    localparam int unsigned BIT_IRQ_OR_WAVE_SELECT = 2;
    localparam int unsigned BIT_RATE_SELECT_LOW    = 3;
    localparam int unsigned BIT_RATE_SELECT_HIGH   = 4;
    localparam int unsigned BIT_OSC_DISABLE        = 7;

    // ------------------------------------------------------------
    // Oscillator divider taps (tick runs at twice the 32.768 kHz rate)
    // ------------------------------------------------------------
    localparam int unsigned OSC_DIV_W    = 16;
    localparam int unsigned TAP_REF      = 0;
    localparam int unsigned TAP_8192HZ   = 2;
    localparam int unsigned TAP_4096HZ   = 3;
    localparam int unsigned TAP_1024HZ   = 5;
    localparam int unsigned TAP_1HZ      = 15;

    localparam logic [1:0] RATE_1HZ      = 2'h0;
    localparam logic [1:0] RATE_1024HZ   = 2'h1;
    localparam logic [1:0] RATE_4096HZ   = 2'h2;

    typedef enum logic [1:0]
    {
        PFR_POWER_FAIL,
        PFR_RECOVER,
        PFR_RUN,
        PFR_PUSH
    } pfr_state_e;

endpackage

// File: pfr_hold_timer.sv
`timescale 1ns/100ps
`default_nettype none

// Raises done once run has stayed high for LIMIT cycles; drops with run
module pfr_hold_timer
#(
    parameter int unsigned LIMIT = 16,
    parameter int unsigned W     = 32
)
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic run,
    output var  logic done
);

    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         done_reg;
    logic         done_next;

    always_comb
    begin
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (!run)
        begin
            cnt_next = '0;
        end
        else
        begin
            done_next = done_reg || (cnt_reg == LAST);
            if (cnt_reg != LAST)
            begin
                cnt_next = cnt_reg + W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;

endmodule

`default_nettype wire

// File: pfr_power_reset.sv
`timescale 1ns/100ps
`default_nettype none

module pfr_power_reset
#(
    parameter int unsigned REC_CYCLES  = pfr_pkg::T_REC_TYP_MS * pfr_pkg::CLK_PER_MS,
    parameter int unsigned PUSH_CYCLES = pfr_pkg::T_RST_ACTIVE_MS * pfr_pkg::CLK_PER_MS,
    parameter int unsigned DB_CYCLES   = pfr_pkg::T_PB_DEBOUNCE_MS * pfr_pkg::CLK_PER_MS,
    parameter int unsigned OSF_CYCLES  = pfr_pkg::T_OSC_STOP_MS * pfr_pkg::CLK_PER_MS
)
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       power_fail,
    input  wire logic       osc_running,
    input  wire logic       osc_tick,
    input  wire logic       alarm1_match,
    input  wire logic       alarm2_match,
    input  wire logic       ref_clock_enable,
    input  wire logic       osc_stopped_clear,
    input  wire logic       ctrl_wr_en,
    input  wire logic [7:0] ctrl_wr_data,
    output var  logic [7:0] ctrl_rd_data,
    input  wire logic       rst_pin_n_i,
    output var  logic       rst_pin_n_o,
    output var  logic       rst_pin_n_oe,
    output var  logic       irq_or_wave_pin_n_o,
    output var  logic       irq_or_wave_pin_n_oe,
    output var  logic       ref_clock_out_o,
    output var  logic       ref_clock_out_oe,
    output var  logic       osc_stopped_flag
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] pf_sync_reg;
    logic [1:0] osc_sync_reg;
    logic [1:0] pin_sync_reg;

    always_ff @(posedge clk)
    begin
        pf_sync_reg  <= {pf_sync_reg[0], power_fail};
        osc_sync_reg <= {osc_sync_reg[0], osc_running};
        pin_sync_reg <= {pin_sync_reg[0], rst_pin_n_i};
    end

    logic pf_s;
    logic osc_s;
    logic pin_s;
    assign pf_s  = pf_sync_reg[1];
    assign osc_s = osc_sync_reg[1];
    assign pin_s = pin_sync_reg[1];

    // ------------------------------------------------------------
    // Control settings register and oscillator divider
    // ------------------------------------------------------------
    logic [7:0]                   ctrl_reg;
    logic [7:0]                   ctrl_next;
    logic [pfr_pkg::OSC_DIV_W-1:0] div_reg;
    logic [pfr_pkg::OSC_DIV_W-1:0] div_next;

    always_comb
    begin
        // Only srst resets this; the reset pin is read back only for the pushbutton, never for these registers
        ctrl_next = ctrl_wr_en ? ctrl_wr_data : ctrl_reg;
        div_next  = osc_tick ? div_reg + pfr_pkg::OSC_DIV_W'(1) : div_reg;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_reg <= pfr_pkg::CONTROL_SETTINGS_RESET;
            div_reg  <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            div_reg  <= div_next;
        end
    end

    logic       irq_or_wave_select;
    logic       osc_disable;
    logic [1:0] rate_sel;
    assign irq_or_wave_select = ctrl_reg[pfr_pkg::BIT_IRQ_OR_WAVE_SELECT];
    assign osc_disable        = ctrl_reg[pfr_pkg::BIT_OSC_DISABLE];
    assign rate_sel           = {ctrl_reg[pfr_pkg::BIT_RATE_SELECT_HIGH],
                                 ctrl_reg[pfr_pkg::BIT_RATE_SELECT_LOW]};

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    pfr_pkg::pfr_state_e state_reg;
    pfr_pkg::pfr_state_e state_next;
    logic                rec_done;
    logic                push_done;
    logic                db_done;
    logic                osf_done;

    // Recovery only advances while the oscillator actually runs
    pfr_hold_timer #(.LIMIT(REC_CYCLES)) u_rec
    (
        .clk  (clk),
        .srst (srst),
        .run  (state_reg == pfr_pkg::PFR_RECOVER && !pf_s && osc_s),
        .done (rec_done)
    );

    pfr_hold_timer #(.LIMIT(PUSH_CYCLES)) u_push
    (
        .clk  (clk),
        .srst (srst),
        .run  (state_reg == pfr_pkg::PFR_PUSH),
        .done (push_done)
    );

    // Pin low only counts as a press while we are not pulling it ourselves
    pfr_hold_timer #(.LIMIT(DB_CYCLES)) u_db
    (
        .clk  (clk),
        .srst (srst),
        .run  (state_reg == pfr_pkg::PFR_RUN && !rst_pin_n_oe && !pin_s),
        .done (db_done)
    );

    pfr_hold_timer #(.LIMIT(OSF_CYCLES)) u_osf
    (
        .clk  (clk),
        .srst (srst),
        .run  (!osc_s),
        .done (osf_done)
    );

    // ------------------------------------------------------------
    // Reset sequencer and pin drivers
    // ------------------------------------------------------------
    logic wave_bit;
    logic alarm_hit;
    logic rst_oe_next;
    logic irq_oe_next;
    logic ref_oe_next;
    logic osf_next;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pfr_pkg::PFR_POWER_FAIL:
            begin
                if (!pf_s)
                begin
                    state_next = osc_disable ? pfr_pkg::PFR_RUN
                                             : pfr_pkg::PFR_RECOVER;
                end
            end
            pfr_pkg::PFR_RECOVER:
            begin
                if (osc_disable || rec_done)
                begin
                    state_next = pfr_pkg::PFR_RUN;
                end
            end
            pfr_pkg::PFR_RUN:
            begin
                if (db_done)
                begin
                    state_next = pfr_pkg::PFR_PUSH;
                end
            end
            pfr_pkg::PFR_PUSH:
            begin
                if (push_done)
                begin
                    state_next = pfr_pkg::PFR_RUN;
                end
            end
            default:
            begin
                state_next = pfr_pkg::PFR_POWER_FAIL;
            end
        endcase
        if (pf_s)
        begin
            state_next = pfr_pkg::PFR_POWER_FAIL;
        end
        rst_oe_next = (state_next != pfr_pkg::PFR_RUN);

        case (rate_sel)
            pfr_pkg::RATE_1HZ:    wave_bit = div_reg[pfr_pkg::TAP_1HZ];
            pfr_pkg::RATE_1024HZ: wave_bit = div_reg[pfr_pkg::TAP_1024HZ];
            pfr_pkg::RATE_4096HZ: wave_bit = div_reg[pfr_pkg::TAP_4096HZ];
            default:              wave_bit = div_reg[pfr_pkg::TAP_8192HZ];
        endcase
        alarm_hit = (alarm1_match && ctrl_reg[pfr_pkg::BIT_ALARM1_IRQ_EN])
                 || (alarm2_match && ctrl_reg[pfr_pkg::BIT_ALARM2_IRQ_EN]);
        // Open drain: enable means pulling low
        irq_oe_next = irq_or_wave_select ? alarm_hit : !wave_bit;
        // No supply input gates this; it keeps running on backup power
        ref_oe_next = ref_clock_enable && !div_reg[pfr_pkg::TAP_REF];
        // Set beats a clear in the same cycle
        osf_next = osf_done || (osc_stopped_flag && !osc_stopped_clear);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg            <= pfr_pkg::PFR_POWER_FAIL;
            rst_pin_n_oe         <= 1'b1;
            irq_or_wave_pin_n_oe <= 1'b0;
            ref_clock_out_oe     <= 1'b0;
            osc_stopped_flag     <= 1'b1;
            ctrl_rd_data         <= pfr_pkg::CONTROL_SETTINGS_RESET;
        end
        else
        begin
            state_reg            <= state_next;
            rst_pin_n_oe         <= rst_oe_next;
            irq_or_wave_pin_n_oe <= irq_oe_next;
            ref_clock_out_oe     <= ref_oe_next;
            osc_stopped_flag     <= osf_next;
            ctrl_rd_data         <= ctrl_next;
        end
    end

    assign rst_pin_n_o         = 1'b0;
    assign irq_or_wave_pin_n_o = 1'b0;
    assign ref_clock_out_o     = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_wave_mode_out: assert property (!irq_or_wave_select |=> irq_or_wave_pin_n_oe == !$past(wave_bit))
        else $error("shared pin does not follow square wave");
    a_alarm_irq_low: assert property (irq_or_wave_select && alarm_hit |=> irq_or_wave_pin_n_oe)
        else $error("enabled alarm match did not pull pin low");
    a_ctrl_reset_val: assert property ($past(srst) |-> ctrl_reg == pfr_pkg::CONTROL_SETTINGS_RESET)
        else $error("control settings wrong after reset");
    a_fail_drives_low: assert property (pf_s |=> rst_pin_n_oe && state_reg == pfr_pkg::PFR_POWER_FAIL)
        else $error("power fail did not drive reset low");
    a_hold_then_free: assert property (state_reg == pfr_pkg::PFR_RECOVER && rec_done && !pf_s |=> !rst_pin_n_oe)
        else $error("reset not released after hold time");
    a_press_asserts: assert property (state_reg == pfr_pkg::PFR_RUN && db_done && !pf_s |=> rst_pin_n_oe ##1 rst_pin_n_oe)
        else $error("debounced press did not assert reset");
    a_recovery_holds: assert property (state_reg == pfr_pkg::PFR_POWER_FAIL && !pf_s && !osc_disable |=> rst_pin_n_oe [*8])
        else $error("reset released before recovery delay");
    a_skip_recovery: assert property (state_reg == pfr_pkg::PFR_POWER_FAIL && !pf_s && osc_disable |=> !rst_pin_n_oe)
        else $error("disabled oscillator did not bypass recovery");
    a_osf_sets: assert property (osf_done |=> osc_stopped_flag)
        else $error("stopped flag not set after stop period");
    a_ref_clock_runs: assert property (ref_clock_enable |=> ref_clock_out_oe == !$past(div_reg[pfr_pkg::TAP_REF]))
        else $error("reference clock output not driven");

endmodule

`default_nettype wire

// File: pfr_far_side.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Far side: pushbutton on the reset line, pull-ups everywhere
// ------------------------------------------------------------
module pfr_far_side
(
    input  wire logic press,
    input  wire logic rst_oe,
    input  wire logic irq_oe,
    input  wire logic ref_oe,
    output var  logic rst_line_n,
    output var  logic irq_line_n,
    output var  logic ref_line
);
    // Open drain: any party pulling wins, else the pull-up gives 1
    always_comb
    begin
        rst_line_n = !(press || rst_oe);
        irq_line_n = !irq_oe;
        ref_line   = !ref_oe;
    end
endmodule

`default_nettype wire

// File: tb_pfr_power_reset.sv
`timescale 1ns/100ps
`default_nettype none

module tb_pfr_power_reset;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       pf = 1'b0;
    logic       osc_run = 1'b1;
    logic       tick = 1'b0;
    logic       tick_on = 1'b0;
    logic       a1 = 1'b1;
    logic       a2 = 1'b1;
    logic       ref_en = 1'b0;
    logic       clr = 1'b0;
    logic       wr_en = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic       press = 1'b0;
    logic [7:0] rd;
    logic       rst_o, rst_oe, irq_o, irq_oe, ref_o, ref_oe, flag;
    logic       rst_line_n, irq_line_n, ref_line;
    int         fails = 0;
    int         checks_done = 0;
    int         seed = 92;
    int         n;
    logic [7:0] d;

    initial forever #25 clk = !clk;
    // Tick every other cycle so divider bit k toggles every 2^(k+1) cycles
    always @(negedge clk) tick <= tick_on & !tick;

    pfr_power_reset #(.REC_CYCLES(16), .PUSH_CYCLES(16), .DB_CYCLES(16), .OSF_CYCLES(16)) dut
    (
        .clk(clk), .srst(srst), .power_fail(pf), .osc_running(osc_run), .osc_tick(tick),
        .alarm1_match(a1), .alarm2_match(a2), .ref_clock_enable(ref_en),
        .osc_stopped_clear(clr), .ctrl_wr_en(wr_en), .ctrl_wr_data(wr_data),
        .ctrl_rd_data(rd), .rst_pin_n_i(rst_line_n), .rst_pin_n_o(rst_o),
        .rst_pin_n_oe(rst_oe), .irq_or_wave_pin_n_o(irq_o), .irq_or_wave_pin_n_oe(irq_oe),
        .ref_clock_out_o(ref_o), .ref_clock_out_oe(ref_oe), .osc_stopped_flag(flag)
    );

    pfr_far_side far
    (
        .press(press), .rst_oe(rst_oe), .irq_oe(irq_oe), .ref_oe(ref_oe),
        .rst_line_n(rst_line_n), .irq_line_n(irq_line_n), .ref_line(ref_line)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] v);
        wr_en = 1'b1;
        wr_data = v;
        step(1);
        wr_en = 1'b0;
        step(3);
    endtask

    task automatic wait_oe(input logic v, input int lim, output int c);
        c = 0;
        while (rst_oe !== v && c < lim)
        begin
            step(1);
            c++;
        end
    endtask

    // Pin transitions seen over 128 cycles; periodic, so the count is exact
    task automatic edges(input logic use_ref, output int c);
        logic last;
        c = 0;
        last = use_ref ? ref_oe : irq_oe;
        repeat (128)
        begin
            step(1);
            if ((use_ref ? ref_oe : irq_oe) !== last)
                c++;
            last = use_ref ? ref_oe : irq_oe;
        end
    endtask

    function automatic int wave_edges(input int r);
        return (r == 3) ? 16 : (r == 2) ? 8 : 2;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        step(10);
        srst = 1'b0;
        step(1);
        chk(rd, 8'h1c);
        chk(irq_oe, 1'b0);
        chk(flag, 1'b1);
        chk(rst_oe, 1'b1);
        chk(rst_line_n, 1'b0);
        chk({rst_o, irq_o, ref_o}, 3'h0);
        wait_oe(1'b0, 40, n);
        chk(n >= 14 && n <= 30, 1'b1);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(2);
        chk(flag, 1'b0);
        repeat (24)
        begin
            d = 8'h04 | ($random(seed) & 8'h03);
            a1 = $random(seed);
            a2 = $random(seed);
            wr(d);
            chk(irq_oe, (a1 & d[0]) | (a2 & d[1]));
            chk(irq_line_n, !((a1 & d[0]) | (a2 & d[1])));
        end
        tick_on = 1'b1;
        for (int r = 1; r < 4; r++)
        begin
            wr({3'h0, r[1:0], 3'h0});
            edges(1'b0, n);
            chk(n, wave_edges(r));
        end
        // Slowest rate: at most one transition fits in the window
        wr(8'h00);
        edges(1'b0, n);
        chk(n <= 1, 1'b1);
        ref_en = 1'b1;
        pf = 1'b1;
        step(3);
        chk(rst_oe, 1'b1);
        edges(1'b1, n);
        chk(n, 64);
        ref_en = 1'b0;
        step(3);
        edges(1'b1, n);
        chk(n, 0);
        chk(ref_line, 1'b1);
        wr(8'h80);
        pf = 1'b0;
        wait_oe(1'b0, 8, n);
        chk(n <= 4, 1'b1);
        press = 1'b1;
        wait_oe(1'b1, 40, n);
        chk(n >= 16 && n < 40, 1'b1);
        press = 1'b0;
        wait_oe(1'b0, 40, n);
        chk(n >= 14 && n < 40, 1'b1);
        chk(rd, 8'h80);
        osc_run = 1'b0;
        step(10);
        chk(flag, 1'b0);
        step(20);
        chk(flag, 1'b1);
        // Clear while the oscillator is still stopped: the set must win
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(2);
        chk(flag, 1'b1);
        osc_run = 1'b1;
        srst = 1'b1;
        step(3);
        srst = 1'b0;
        step(1);
        chk(rd, 8'h1c);
        chk(flag, 1'b1);
        chk(rst_oe, 1'b1);
        chk(irq_oe, 1'b0);
        // Disabling the oscillator mid-recovery releases before the count ends
        step(8);
        wr(8'h9c);
        chk(rst_oe, 1'b0);
        chk(rd, 8'h9c);
        end_of_test();
    end

    initial
    begin
        #(4000 * 50);
        fails++;
        end_of_test();
    end
endmodule

`default_nettype wire
